// >>> dv/tb.sv
// Self-checking bench for the baud divider and break control block.
`timescale 1ns/1ps

module tb;
  logic sys_clk = 1'b0, rst = 1'b1, cpuWrEn = 1'b0, cpuRdEn = 1'b0;
  logic portPower = 1'b0, txEnable = 1'b0, rxEnable = 1'b0;
  logic timerOut = 1'b0, txValid = 1'b0;
  logic txReady, rxPin, serialOut, txDoneIrq, rxBreakIrq;
  logic breakRxBusy, bitRateClk;
  logic [15:0] cpuAddr = 16'h0000;
  logic [7:0] cpuWrData = 8'h00, txData = 8'h00, cpuRdData;
  logic [3:0] baseClockCode = 4'h0;
  int errorCnt = 0, testsRun = 0, cyc = 0, n, n0, i, t;
  bit ok, full;

  ubd_top DUT (.sys_clk(sys_clk), .rst(rst), .cpuAddr(cpuAddr),
    .cpuWrEn(cpuWrEn), .cpuWrData(cpuWrData), .cpuRdEn(cpuRdEn),
    .cpuRdData(cpuRdData), .portPower(portPower), .txEnable(txEnable),
    .rxEnable(rxEnable), .baseClockCode(baseClockCode),
    .timerOut(timerOut), .txValid(txValid), .txReady(txReady),
    .txData(txData), .rxPin(rxPin), .serialOut(serialOut),
    .txDoneIrq(txDoneIrq), .rxBreakIrq(rxBreakIrq),
    .breakRxBusy(breakRxBusy), .bitRateClk(bitRateClk));
  ubd_node node (.sys_clk(sys_clk), .lineIn(serialOut), .lineOut(rxPin));

  // Clock at 100 MHz and a cycle counter that cuts a hang short.
  initial begin
    forever #5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errorCnt++;
      giveVerdict();
    end
  end

  task automatic giveVerdict();
    if (errorCnt == 0 && testsRun > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] exp, got);
    testsRun++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", nm, exp, got);
      errorCnt++;
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    cpuAddr = a;
    cpuWrData = d;
    cpuWrEn = 1'b1;
    @(negedge sys_clk);
    cpuWrEn = 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(negedge sys_clk);
    cpuAddr = a;
    cpuRdEn = 1'b1;
    @(negedge sys_clk);
    cpuRdEn = 1'b0;
    chk("read data", {8'h00, e}, {8'h00, cpuRdData});
  endtask
  task automatic wt(input bit r);
    for (int k = 0; k < 4000 && !(r ? rxBreakIrq : txDoneIrq); k++)
      @(negedge sys_clk);
    chk("event pulse", 16'h0001, {15'h0000, r ? rxBreakIrq : txDoneIrq});
  endtask
  task automatic push(input logic [7:0] d, output bit acc);
    @(negedge sys_clk);
    txValid = 1'b1;
    txData = d;
    acc = txReady;
  endtask

  // Measures one bit period after a power cycle with a new base code.
  task automatic period(input logic [3:0] code, input int exp);
    portPower = 1'b0;
    baseClockCode = code;
    @(negedge sys_clk);
    portPower = 1'b1;
    @(posedge bitRateClk);
    @(negedge sys_clk);
    t = cyc;
    @(posedge bitRateClk);
    @(negedge sys_clk);
    chk("bit period", 16'(exp), 16'(cyc - t));
  endtask

  // Timer output for the timer-fed base clock, one rise per 8 cycles.
  always @(negedge sys_clk) begin
    if (cyc % 4 == 0) timerOut <= ~timerOut;
  end

  // Main sequence; every input changes at a falling edge.
  initial begin
    repeat (12) @(posedge sys_clk);
    @(negedge sys_clk);
    rst = 1'b0;
    rd(16'hFF57, 8'hFF);
    rd(16'hFF58, 8'h16);
    rd(16'hFF50, 8'h00);
    wr(16'hFF57, 8'h08);
    wr(16'hFF58, 8'h14);
    rd(16'hFF57, 8'h08);
    period(4'h1, 32);
    period(4'hB, 128);
    period(4'h0, 16);
    txEnable = 1'b1;
    for (int c = 0; c < 8; c++) begin
      wr(16'hFF58, 8'h20 | 8'(c << 2));
      wt(1'b0);
      repeat (2) @(negedge sys_clk);
      n = ((c + 3) % 8 + 13) * 16;
      chk("break low", 16'(n), node.lowLen);
      rd(16'hFF58, 8'(c << 2));
    end
    wr(16'hFF58, 8'h14);
    n0 = node.rxCnt;
    n = 0;
    full = 1'b0;
    repeat (20) begin
      push(8'h40 + 8'(n), ok);
      if (ok) n++;
      else full = 1'b1;
    end
    @(negedge sys_clk);
    txValid = 1'b0;
    chk("queue refused", 16'h0001, {15'h0000, full});
    wr(16'hFF57, 8'h08);
    wr(16'hFF58, 8'h14);
    for (i = 0; i < 3000 && node.rxCnt < n0 + n; i++) @(negedge sys_clk);
    chk("frames", 16'(n0 + n), 16'(node.rxCnt));
    chk("last byte", 16'h003F + 16'(n), {8'h00, node.rxByte});
    rxEnable = 1'b1;
    wr(16'hFF58, 8'h54);
    rd(16'hFF58, 8'h94);
    node.brk(8);
    repeat (40) @(negedge sys_clk);
    chk("busy after short", 16'h0001, {15'h0000, breakRxBusy});
    node.brk(12);
    wt(1'b1);
    repeat (3) @(negedge sys_clk);
    chk("busy after break", 16'h0000, {15'h0000, breakRxBusy});
    rd(16'hFF58, 8'h14);
    txEnable = 1'b0;
    rxEnable = 1'b0;
    wr(16'hFF58, 8'h16);
    txEnable = 1'b1;
    n0 = node.rxCnt;
    ok = 1'b0;
    while (!ok) push(8'h4B, ok);
    @(negedge sys_clk);
    txValid = 1'b0;
    for (i = 0; i < 3000 && node.rxCnt == n0; i++) @(negedge sys_clk);
    chk("lsb first byte", 16'h00D2, {8'h00, node.rxByte});
    txEnable = 1'b0;
    wr(16'hFF58, 8'h15);
    repeat (4) @(negedge sys_clk);
    chk("inverted idle", 16'h0000, {15'h0000, serialOut});
    portPower = 1'b0;
    repeat (4) @(negedge sys_clk);
    chk("line powered off", 16'h0001, {15'h0000, serialOut});
    giveVerdict();
  end
endmodule // tb

bind ubd_top ubd_chk uChk (.sys_clk(sys_clk), .rst(rst),
  .cpuAddr(cpuAddr), .cpuWrEn(cpuWrEn), .cpuWrData(cpuWrData),
  .cpuRdEn(cpuRdEn), .cpuRdData(cpuRdData), .portPower(portPower),
  .rxEnable(rxEnable), .serialOut(serialOut), .txDoneIrq(txDoneIrq),
  .rxBreakIrq(rxBreakIrq), .breakRxBusy(breakRxBusy),
  .bitRateClk(bitRateClk));

// >>> dv/ubd_node.sv
// Remote line node: sends breaks and decodes frames from the port.
`timescale 1ns/1ps

module ubd_node #(
  parameter int BIT_CYC = 16
) (
  // Clock.
  input wire logic sys_clk,
  // Line from the port and line to the port.
  input wire logic lineIn,
  output logic lineOut
);
  logic [15:0] lowCnt = 16'h0000;
  logic [15:0] lowLen = 16'h0000;
  logic [7:0] rxByte = 8'h00;
  logic [7:0] sh;
  int rxCnt = 0;

  initial lineOut = 1'b1;

  // Holds the line low for n bit periods, then drives it high again for idle.
  task automatic brk(input int n);
    @(negedge sys_clk);
    lineOut = 1'b0;
    repeat (n * BIT_CYC) @(negedge sys_clk);
    lineOut = 1'b1;
  endtask

  // Measures each low stretch of the port's line in clock cycles.
  always @(posedge sys_clk) begin
    if (!lineIn) begin
      lowCnt <= lowCnt + 16'h0001;
    end else begin
      if (lowCnt != 16'h0000) lowLen <= lowCnt;
      lowCnt <= 16'h0000;
    end
  end

  // Samples eight bits at mid-bit, first bit landing in the top bit.
  always begin
    @(negedge lineIn);
    repeat (BIT_CYC + BIT_CYC / 2) @(posedge sys_clk);
    for (int i = 0; i < 8; i++) begin
      sh = {sh[6:0], lineIn};
      repeat (BIT_CYC) @(posedge sys_clk);
    end
    rxByte = sh;
    rxCnt++;
  end
endmodule // ubd_node

// >>> dv/ubd_top_asserts.sv
// Port-level checker for the baud divider and break control block.
`timescale 1ns/1ps

module ubd_chk (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rst,
  // Register port.
  input wire logic [15:0] cpuAddr,
  input wire logic cpuWrEn,
  input wire logic [7:0] cpuWrData,
  input wire logic cpuRdEn,
  input wire logic [7:0] cpuRdData,
  // Mode bits.
  input wire logic portPower,
  input wire logic rxEnable,
  // Line, events and status.
  input wire logic serialOut,
  input wire logic txDoneIrq,
  input wire logic rxBreakIrq,
  input wire logic breakRxBusy,
  input wire logic bitRateClk
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  // A control write that arms break reception, and a held power-off.
  sequence s_arm;
    cpuWrEn && cpuAddr == 16'hFF58 && cpuWrData[6] && portPower && rxEnable;
  endsequence
  sequence s_off;
    !portPower [*3];
  endsequence
  sequence s_rd_ctl;
    cpuRdEn && cpuAddr == 16'hFF58;
  endsequence

  a_arm_sets_busy: assert property (
    s_arm |-> ##[1:2] breakRxBusy)
    else $error("busy flag not set after arming");
  a_ok_clears_busy: assert property (
    rxBreakIrq |-> ##[0:2] !breakRxBusy)
    else $error("busy flag kept after good break");
  a_off_clears_busy: assert property (
    s_off |-> !breakRxBusy)
    else $error("busy flag kept while powered off");
  a_off_line_high: assert property (
    s_off |-> serialOut)
    else $error("line not high while powered off");
  a_trig_read_zero: assert property (
    s_rd_ctl |=> cpuRdData[6:5] == 2'h0)
    else $error("trigger bit read as one");
  a_read_busy_bit: assert property (
    s_rd_ctl |=> cpuRdData[7] == breakRxBusy)
    else $error("status bit differs from busy output");
  a_tx_irq_pulse: assert property (
    txDoneIrq |=> !txDoneIrq [*8])
    else $error("transmit done pulse too long");
  a_bit_half_min: assert property (
    $rose(bitRateClk) |-> (bitRateClk || !portPower) [*8])
    else $error("bit clock half period below eight");
endmodule // ubd_chk

// >>> hw/ubd_map.svh
// Register map, field positions, reset values and timing counts.
`ifndef UBD_MAP_SVH
`define UBD_MAP_SVH
`define UBD_DIV_ADDR 16'hFF57
`define UBD_CTL_ADDR 16'hFF58
`define UBD_DIV_RST 8'hFF
`define UBD_CTL_RST 8'h16
`define UBD_DIV_MIN 8'h08
`define UBD_BIT_RXBUSY 7
`define UBD_BIT_RXTRIG 6
`define UBD_BIT_TXTRIG 5
`define UBD_BIT_ORDER 1
`define UBD_BIT_INV 0
`define UBD_CODE_MAX 4'hA
`define UBD_CODE_TIMER 4'hB
`define UBD_BRK_MIN 5'h0B
`define UBD_FRAME_BITS 5'h0A
`endif

// >>> hw/ubd_pkg.sv
// Types shared by the baud divider and break control block.
package ubd_pkg;
  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_DATA = 2'b01,
    TX_BRK = 2'b10
  } ubd_tx_state_t;
endpackage

// >>> hw/ubd_top.sv
// Baud divider, break control and transmit path with its FIFO.
`timescale 1ns/1ps
`include "ubd_map.svh"

module ubd_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic flush,
  // Filling side.
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  // Draining side.
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr_r;
  logic [AW-1:0] rdPtr_r;
  logic [AW:0] count_r;
  logic push;
  logic pop;

  // Handshakes on both sides.
  assign push = inValid && inReady;
  assign pop = outValid && outReady;
  assign inReady = (count_r != (AW+1)'(DEPTH));
  assign outValid = (count_r != '0);
  assign outData = mem[rdPtr_r];

  // Storage array.
  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wrPtr_r] <= inData;
    end
  end

  // Pointers and fill level.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      count_r <= '0;
    end else if (flush) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      count_r <= '0;
    end else begin
      if (push) begin
        wrPtr_r <= AW'(wrPtr_r + 1'b1);
      end
      if (pop) begin
        rdPtr_r <= AW'(rdPtr_r + 1'b1);
      end
      count_r <= (AW+1)'(count_r + push - pop);
    end
  end
endmodule // ubd_fifo

module ubd_top import ubd_pkg::*; (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rst,
  // CPU register port.
  input wire logic [15:0] cpuAddr,
  input wire logic cpuWrEn,
  input wire logic [7:0] cpuWrData,
  input wire logic cpuRdEn,
  output logic [7:0] cpuRdData,
  // Mode bits and base clock selection.
  input wire logic portPower,
  input wire logic txEnable,
  input wire logic rxEnable,
  input wire logic [3:0] baseClockCode,
  input wire logic timerOut,
  // Transmit data stream.
  input wire logic txValid,
  output logic txReady,
  input wire logic [7:0] txData,
  // Serial line.
  input wire logic rxPin,
  output logic serialOut,
  // Events and status.
  output logic txDoneIrq,
  output logic rxBreakIrq,
  output logic breakRxBusy,
  output logic bitRateClk
);
  logic [7:0] divisor_r;
  logic [4:0] ctl_r;
  logic rxTrig_r;
  logic rxBusy_r;
  logic txTrig_r;
  logic [2:0] rxSync_r;
  logic [2:0] tmSync_r;
  logic rxLine_r;
  logic rxLinePrev_r;
  logic tmLevel_r;
  logic tmPrev_r;
  logic [9:0] preCnt_r;
  logic [7:0] divCnt_r;
  logic half_r;
  logic baseTick;
  logic divPulse;
  logic bitTick;
  ubd_tx_state_t txState_r;
  logic [9:0] shift_r;
  logic [4:0] bitsLeft_r;
  logic [4:0] lowCnt_r;
  logic fifoValid;
  logic fifoPop;
  logic fifoReady;
  logic [7:0] fifoData;
  logic wrDiv;
  logic wrCtl;
  logic txActive;
  logic lineBit;

  // Mask of prescaler bits for a divide by two to the code.
  function automatic logic [9:0] preMask(input logic [3:0] code);
    preMask = 10'((11'h001 << code) - 11'h001);
  endfunction

  // Break low time in bit periods from the length code.
  function automatic logic [4:0] brkLen(input logic [2:0] code);
    brkLen = (code < 3'h5) ? 5'(5'h10 + code) : 5'(5'h08 + code);
  endfunction

  // Byte order for the shifter: reversed when MSB goes first.
  function automatic logic [7:0] orderByte(input logic [7:0] b,
                                           input logic lsbFirst);
    orderByte = lsbFirst ? b : {b[0], b[1], b[2], b[3],
                                b[4], b[5], b[6], b[7]};
  endfunction

  assign wrDiv = cpuWrEn && (cpuAddr == `UBD_DIV_ADDR);
  assign wrCtl = cpuWrEn && (cpuAddr == `UBD_CTL_ADDR);
  assign txActive = portPower && txEnable;

  // Divisor register; a write leaves the counter untouched.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      divisor_r <= `UBD_DIV_RST;
    end else if (wrDiv) begin
      divisor_r <= cpuWrData;
    end
  end

  // Length code, bit order and inversion fields.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ctl_r <= 5'(`UBD_CTL_RST);
    end else if (wrCtl) begin
      ctl_r <= cpuWrData[4:0];
    end
  end

  // Three-stage synchronisers; a change counts when stages agree.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rxSync_r <= 3'h7;
      tmSync_r <= 3'h0;
      rxLine_r <= 1'b1;
      tmLevel_r <= 1'b0;
    end else begin
      rxSync_r <= {rxSync_r[1:0], rxPin};
      tmSync_r <= {tmSync_r[1:0], timerOut};
      if (rxSync_r[1] == rxSync_r[2]) begin
        rxLine_r <= portPower ? rxSync_r[2] : 1'b1;
      end
      if (tmSync_r[1] == tmSync_r[2]) begin
        tmLevel_r <= tmSync_r[2];
      end
    end
  end

  // Edge history of the filtered line and timer levels.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rxLinePrev_r <= 1'b1;
      tmPrev_r <= 1'b0;
    end else begin
      rxLinePrev_r <= rxLine_r;
      tmPrev_r <= tmLevel_r;
    end
  end

  // Base clock: power-of-two prescale or timer edges.
  always_comb begin
    if (baseClockCode <= `UBD_CODE_MAX) begin
      baseTick = portPower &&
        ((preCnt_r & preMask(baseClockCode)) ==
         preMask(baseClockCode));
    end else if (baseClockCode == `UBD_CODE_TIMER) begin
      baseTick = portPower && tmLevel_r && !tmPrev_r;
    end else begin
      baseTick = 1'b0;
    end
  end

  // Free-running prescaler, cleared to zero while the port is off.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      preCnt_r <= '0;
    end else if (!portPower) begin
      preCnt_r <= '0;
    end else begin
      preCnt_r <= 10'(preCnt_r + 1'b1);
    end
  end

  // Divide-by-k counter; divisors below 8 block its pulse while it keeps counting.
  assign divPulse = baseTick && (divisor_r >= `UBD_DIV_MIN) &&
                    (divCnt_r >= 8'(divisor_r - 1'b1));
  assign bitTick = divPulse && half_r;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      divCnt_r <= '0;
      half_r <= 1'b0;
    end else if (!portPower) begin
      divCnt_r <= '0;
      half_r <= 1'b0;
    end else if (baseTick) begin
      divCnt_r <= divPulse ? 8'h00 : 8'(divCnt_r + 1'b1);
      half_r <= half_r ^ divPulse;
    end
  end

  // Transmit data queue.
  ubd_fifo #(.WIDTH(8), .DEPTH(4)) txFifo (
    .sys_clk(sys_clk),
    .rst(rst),
    .flush(!txActive),
    .inValid(txValid && txReady),
    .inReady(fifoReady),
    .inData(txData),
    .outValid(fifoValid),
    .outReady(fifoPop),
    .outData(fifoData)
  );

  assign fifoPop = bitTick && (txState_r == TX_IDLE) && !txTrig_r &&
                   fifoValid;

  // Ready flag registered from the queue's fill state; it drops for one
  // cycle after each accepted byte, so a stale flag never offers room
  // that the last push has already taken.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      txReady <= 1'b0;
    end else begin
      txReady <= fifoReady && txActive && !(txValid && txReady);
    end
  end

  // Transmit break trigger: set by a write, cleared when sent.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      txTrig_r <= 1'b0;
    end else if (!txActive) begin
      txTrig_r <= 1'b0;
    end else if (wrCtl && cpuWrData[`UBD_BIT_TXTRIG]) begin
      txTrig_r <= 1'b1;
    end else if (txState_r == TX_BRK && bitTick && bitsLeft_r == 5'h01) begin
      txTrig_r <= 1'b0;
    end
  end

  // Transmit sequencer: data frames and break fields.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      txState_r <= TX_IDLE;
      shift_r <= 10'h3FF;
      bitsLeft_r <= '0;
      txDoneIrq <= 1'b0;
    end else if (!txActive) begin
      txState_r <= TX_IDLE;
      shift_r <= 10'h3FF;
      bitsLeft_r <= '0;
      txDoneIrq <= 1'b0;
    end else begin
      txDoneIrq <= 1'b0;
      case (txState_r)
        TX_IDLE: begin
          if (bitTick && txTrig_r) begin
            shift_r <= 10'h000;
            bitsLeft_r <= brkLen(ctl_r[4:2]);
            txState_r <= TX_BRK;
          end else if (fifoPop) begin
            shift_r <= {1'b1, orderByte(fifoData,
                        ctl_r[`UBD_BIT_ORDER]), 1'b0};
            bitsLeft_r <= `UBD_FRAME_BITS;
            txState_r <= TX_DATA;
          end
        end
        TX_DATA, TX_BRK: begin
          if (bitTick) begin
            shift_r <= {1'b1, shift_r[9:1]};
            bitsLeft_r <= 5'(bitsLeft_r - 1'b1);
            if (bitsLeft_r == 5'h01) begin
              txState_r <= TX_IDLE;
              txDoneIrq <= 1'b1;
            end
          end
        end
        default: begin
          txState_r <= TX_IDLE;
        end
      endcase
    end
  end

  // Line level: data bits from the shifter, a break held low throughout.
  assign lineBit = (txState_r == TX_DATA) ? shift_r[0] :
                   (txState_r != TX_BRK);

  // Pin driver: inversion applied, idle high while powered off.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      serialOut <= 1'b1;
    end else begin
      serialOut <= portPower ?
        (lineBit ^ ctl_r[`UBD_BIT_INV]) : 1'b1;
    end
  end

  // Low-time counter of the received line in bit periods.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      lowCnt_r <= '0;
    end else if (rxLine_r || !rxBusy_r) begin
      lowCnt_r <= '0;
    end else if (bitTick && lowCnt_r != 5'h1F) begin
      lowCnt_r <= 5'(lowCnt_r + 1'b1);
    end
  end

  // Break reception: trigger, busy flag and completion pulse.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rxTrig_r <= 1'b0;
      rxBusy_r <= 1'b0;
      rxBreakIrq <= 1'b0;
    end else if (!portPower || !rxEnable) begin
      rxTrig_r <= 1'b0;
      rxBusy_r <= 1'b0;
      rxBreakIrq <= 1'b0;
    end else begin
      rxBreakIrq <= 1'b0;
      if (wrCtl && cpuWrData[`UBD_BIT_RXTRIG]) begin
        rxTrig_r <= 1'b1;
        rxBusy_r <= 1'b1;
      end else if (rxBusy_r && rxLine_r && !rxLinePrev_r) begin
        if (lowCnt_r >= `UBD_BRK_MIN) begin
          rxTrig_r <= 1'b0;
          rxBusy_r <= 1'b0;
          rxBreakIrq <= 1'b1;
        end else begin
          rxBusy_r <= 1'b1;
        end
      end
    end
  end

  // Register reads; trigger bits always read as zero.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cpuRdData <= 8'h00;
    end else if (cpuRdEn && cpuAddr == `UBD_DIV_ADDR) begin
      cpuRdData <= divisor_r;
    end else if (cpuRdEn && cpuAddr == `UBD_CTL_ADDR) begin
      cpuRdData <= {rxBusy_r, 2'b00, ctl_r};
    end else begin
      cpuRdData <= 8'h00;
    end
  end

  // Status and bit-rate clock outputs.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      breakRxBusy <= 1'b0;
      bitRateClk <= 1'b0;
    end else begin
      breakRxBusy <= rxBusy_r;
      bitRateClk <= half_r;
    end
  end
endmodule // ubd_top
